/* design/freq_check.sv */
// crystal against divided RC frequency comparator
`timescale 1ns/10ps
module freq_check
  import osc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  osc_cmp_if.meter cmp
);
  logic rcDly_q;
  logic xtalDly_q;
  logic [2:0] rcCnt_q;
  logic [1:0] xtalCnt_q;
  logic fail_q;
  logic verdict_q;
  logic rcRise;
  logic xtalRise;
  logic [1:0] xtalSum;

  assign rcRise = cmp.rcLevel & ~rcDly_q;
  assign xtalRise = cmp.xtalLevel & ~xtalDly_q;
  // saturating so a fast crystal cannot wrap to zero
  assign xtalSum = (xtalRise && xtalCnt_q != 2'h3) ? xtalCnt_q + 2'h1 : xtalCnt_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rcDly_q <= 1'b0;
      xtalDly_q <= 1'b0;
      rcCnt_q <= 3'h0;
      xtalCnt_q <= 2'h0;
      fail_q <= 1'b1;
      verdict_q <= 1'b0;
    end
    else
    begin
      rcDly_q <= cmp.rcLevel;
      xtalDly_q <= cmp.xtalLevel;
      verdict_q <= 1'b0;
      if (!cmp.enable)
      begin
        rcCnt_q <= 3'h0;
        xtalCnt_q <= 2'h0;
      end
      else if (rcRise && rcCnt_q == RC_DIVIDE - 3'h1)
      begin
        rcCnt_q <= 3'h0;
        xtalCnt_q <= 2'h0;
        verdict_q <= 1'b1;
        fail_q <= (xtalSum < XTAL_MIN_EDGES);
      end
      else
      begin
        if (rcRise)
        begin
          rcCnt_q <= rcCnt_q + 3'h1;
        end
        xtalCnt_q <= xtalSum;
      end
    end
  end

  assign cmp.fail = fail_q;
  assign cmp.verdict = verdict_q;
endmodule

/* design/osc_cmp_if.sv */
// carrier between the supervisor and its frequency comparator
`timescale 1ns/10ps
interface osc_cmp_if;
  logic enable;
  logic rcLevel;
  logic xtalLevel;
  logic fail;
  logic verdict;
  modport meter (input enable, input rcLevel, input xtalLevel, output fail, output verdict);
  modport owner (output enable, output rcLevel, output xtalLevel, input fail, input verdict);
endinterface

/* design/osc_pkg.sv */
// constants, register map and state types for the oscillator supervisor and power modes
// Notes on behaviour
// - oscillator supervision runs except in power-down; it has no software enable bit.
// - reference is the RC clock divided by five; slower crystal means failure.
// - on failure the system clock is switched to the RC source.
// - on failure the chip reset is asserted and held while failure lasts.
// - failure reset acts as external reset but keeps dog flag, halts dog, sets flag.
// - after recovery a final reset phase of about 1 ms keeps RC and reset.
// - after the final phase the crystal is selected and reset request withdrawn.
// - a still active external reset keeps the chip in reset.
// - software sets and clears the failure flag; external reset clears both flags.
// - power-down stops both oscillators; low wake pin with wake enable restarts them.
// - wake from power-down ends in a wake interrupt, not a reset.
// - at power-on the crystal counts as failed; reset runs from RC within 34 us.
// - wake control register is reachable only while the map select bit is set.
// - power-down wins over idle when both are requested together.
// - power-down starts only after arming; the go write is the last step.
// - idle starts only after arming; the go write is the last step.
// - two general purpose flags read and write freely, no hardware effect.
// - idle gates the CPU clock; peripherals except the dog timer keep clocking.
// - all CPU state is kept during idle.
// - ports hold their levels in idle; active alternate outputs keep driving.
// - address latch and store strobes high in idle, low in power-down.
// - arm and go for idle written together do nothing; both read as zero.
// - arm and go for power-down written together do nothing; both read zero.
// - an enabled interrupt or a hardware reset ends idle.
package osc_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_MODE = 8'h87;
  localparam logic [7:0] ADDR_WAKE_CTRL = 8'h88;
  localparam logic [7:0] ADDR_SYSTEM_CTRL = 8'hB1;
  localparam logic [7:0] ADDR_DOG_CTRL = 8'hC0;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_SLEEP_ARM = 0;
  localparam int BIT_PD_ARM = 1;
  localparam int BIT_GP_FLAG_ZERO = 2;
  localparam int BIT_GP_FLAG_ONE = 3;
  localparam int BIT_SLEEP_GO = 5;
  localparam int BIT_PD_GO = 6;
  localparam int BIT_BAUD_DOUBLE = 7;
  localparam int BIT_PD_WAKE_ENABLE = 7;
  localparam int BIT_SFR_MAP_SELECT = 4;
  localparam int BIT_OSC_FAIL_FLAG = 3;
  localparam int BIT_DOG_FLAG = 2;
  localparam logic [7:0] RESET_VALUE_REG = 8'h00;
  // ---------------------------------------------------------------
  // pin index in the input synchroniser
  // ---------------------------------------------------------------
  localparam int PIN_RC = 0;
  localparam int PIN_XTAL = 1;
  localparam int PIN_WAKE = 2;
  localparam int PIN_RESET = 3;
  localparam int PIN_COUNT = 4;
  // ---------------------------------------------------------------
  // comparison and timing
  // ---------------------------------------------------------------
  localparam logic [2:0] RC_DIVIDE = 3'h5;
  localparam logic [1:0] XTAL_MIN_EDGES = 2'h1;
  localparam int CLK_PERIOD_NS = 8;
  localparam int FINAL_RESET_MS = 1;
  localparam int FINAL_RESET_CYCLES = FINAL_RESET_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POWER_ON_MAX_US = 34;
  localparam int POWER_ON_MAX_CYCLES = POWER_ON_MAX_US * 1000 / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SUP_FAIL = 2'h0,
    SUP_FINAL = 2'h1,
    SUP_GOOD = 2'h3
  } sup_state_t;
  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_PD = 2'h1,
    MODE_WAKE = 2'h3,
    MODE_IDLE = 2'h2
  } power_mode_t;
endpackage

/* design/osc_supervisor_power_modes.sv */
// oscillator supervision, clock switchover, reset control and idle / power-down modes
`timescale 1ns/10ps
module osc_supervisor_power_modes
  import osc_pkg::*;
#(
  parameter int FINAL_CYCLES = FINAL_RESET_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rcClkPin,
  input wire logic xtalClkPin,
  input wire logic extWakePin,
  input wire logic extResetPin,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  input wire logic irqPending,
  input wire logic dogResetEvent,
  input wire logic aleCore,
  input wire logic progStoreStrobeCore,
  output logic aleOut,
  output logic progStoreStrobe,
  output logic sysClkSelRc,
  output logic rcOscRun,
  output logic xtalOscRun,
  output logic chipReset,
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic dogHalt,
  output logic portHold,
  output logic pdWakeIrq
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [PIN_COUNT-1:0] pinSync1_q;
  logic [PIN_COUNT-1:0] pinSync2_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pinSync1_q <= '0;
      pinSync2_q <= '0;
    end
    else
    begin
      pinSync1_q <= {extResetPin, extWakePin, xtalClkPin, rcClkPin};
      pinSync2_q <= pinSync1_q;
    end
  end

  logic extRst;
  assign extRst = pinSync2_q[PIN_RESET];

  // ---------------------------------------------------------------
  // frequency comparator
  // ---------------------------------------------------------------
  osc_cmp_if cmp ();
  power_mode_t mode_q;
  sup_state_t supState_q;

  // enable has no software bit of its own; it depends only on mode_q not being MODE_PD, which software enters through pdStart
  assign cmp.enable = (mode_q != MODE_PD);
  assign cmp.rcLevel = pinSync2_q[PIN_RC];
  assign cmp.xtalLevel = pinSync2_q[PIN_XTAL];

  freq_check meter (
    .clk_sys(clk_sys),
    .rst(rst),
    .cmp(cmp)
  );

  logic failSeen;
  logic goodSeen;
  assign failSeen = cmp.verdict & cmp.fail;
  assign goodSeen = cmp.verdict & ~cmp.fail;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic sleepArmed_q;
  logic pdArmed_q;
  logic gpFlagZero_q;
  logic gpFlagOne_q;
  logic baudDouble_q;
  logic pdWakeEnable_q;
  logic sfrMapSelect_q;
  logic oscFailResetFlag_q;
  logic timerDogResetFlag_q;
  logic chipReset_q;

  logic powerModeWr;
  logic wakeCtrlWr;
  logic systemCtrlWr;
  logic dogCtrlWr;
  assign powerModeWr = sfrWrEn && sfrAddr == ADDR_POWER_MODE;
  assign wakeCtrlWr = sfrWrEn && sfrAddr == ADDR_WAKE_CTRL && sfrMapSelect_q;
  assign systemCtrlWr = sfrWrEn && sfrAddr == ADDR_SYSTEM_CTRL;
  assign dogCtrlWr = sfrWrEn && sfrAddr == ADDR_DOG_CTRL;

  // ---------------------------------------------------------------
  // mode requests
  // ---------------------------------------------------------------
  logic sleepStart;
  logic pdStart;
  logic pdWake;
  logic oscReset;
  logic finalDone;
  logic [16:0] finalCnt_q;

  // go only counts when the previous power mode write armed and this one leaves arm clear
  assign sleepStart = powerModeWr && sleepArmed_q && sfrWrData[BIT_SLEEP_GO]
                      && !sfrWrData[BIT_SLEEP_ARM];
  assign pdStart = powerModeWr && pdArmed_q && sfrWrData[BIT_PD_GO]
                   && !sfrWrData[BIT_PD_ARM];
  assign pdWake = mode_q == MODE_PD && !pinSync2_q[PIN_WAKE] && pdWakeEnable_q;
  // a wake start-up runs the same supervision but raises no reset
  assign oscReset = supState_q != SUP_GOOD && mode_q != MODE_WAKE;
  assign finalDone = supState_q == SUP_FINAL && !failSeen
                     && finalCnt_q == 17'(FINAL_CYCLES - 1);

  // ---------------------------------------------------------------
  // supervisor
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      supState_q <= SUP_FAIL;
      finalCnt_q <= 17'h0;
    end
    else if (pdWake)
    begin
      supState_q <= SUP_FAIL;
      finalCnt_q <= 17'h0;
    end
    else if (mode_q != MODE_PD)
    begin
      case (supState_q)
        SUP_FAIL:
        begin
          finalCnt_q <= 17'h0;
          if (goodSeen)
          begin
            supState_q <= SUP_FINAL;
          end
        end
        SUP_FINAL:
        begin
          finalCnt_q <= finalCnt_q + 17'h1;
          if (failSeen)
          begin
            supState_q <= SUP_FAIL;
          end
          else if (finalDone)
          begin
            supState_q <= SUP_GOOD;
          end
        end
        SUP_GOOD:
        begin
          if (failSeen)
          begin
            supState_q <= SUP_FAIL;
          end
        end
        default:
        begin
          supState_q <= SUP_FAIL;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // power mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= MODE_RUN;
    end
    else if (extRst || oscReset)
    begin
      mode_q <= MODE_RUN;
    end
    else
    begin
      case (mode_q)
        MODE_RUN:
        begin
          if (pdStart)
          begin
            mode_q <= MODE_PD;
          end
          else if (sleepStart)
          begin
            mode_q <= MODE_IDLE;
          end
        end
        MODE_IDLE:
        begin
          if (irqPending)
          begin
            mode_q <= MODE_RUN;
          end
        end
        MODE_PD:
        begin
          if (pdWake)
          begin
            mode_q <= MODE_WAKE;
          end
        end
        MODE_WAKE:
        begin
          if (finalDone)
          begin
            mode_q <= MODE_RUN;
          end
        end
        default:
        begin
          mode_q <= MODE_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // power mode control, wake control and system control registers
  // ---------------------------------------------------------------
  // arm and go never store; an arm lives only until the next power mode write or chip reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sleepArmed_q <= 1'b0;
      pdArmed_q <= 1'b0;
    end
    else if (chipReset_q)
    begin
      sleepArmed_q <= 1'b0;
      pdArmed_q <= 1'b0;
    end
    else if (powerModeWr)
    begin
      sleepArmed_q <= sfrWrData[BIT_SLEEP_ARM] && !sfrWrData[BIT_SLEEP_GO];
      pdArmed_q <= sfrWrData[BIT_PD_ARM] && !sfrWrData[BIT_PD_GO];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      gpFlagZero_q <= RESET_VALUE_REG[BIT_GP_FLAG_ZERO];
      gpFlagOne_q <= RESET_VALUE_REG[BIT_GP_FLAG_ONE];
      baudDouble_q <= RESET_VALUE_REG[BIT_BAUD_DOUBLE];
      pdWakeEnable_q <= RESET_VALUE_REG[BIT_PD_WAKE_ENABLE];
      sfrMapSelect_q <= RESET_VALUE_REG[BIT_SFR_MAP_SELECT];
    end
    else if (chipReset_q)
    begin
      gpFlagZero_q <= RESET_VALUE_REG[BIT_GP_FLAG_ZERO];
      gpFlagOne_q <= RESET_VALUE_REG[BIT_GP_FLAG_ONE];
      baudDouble_q <= RESET_VALUE_REG[BIT_BAUD_DOUBLE];
      pdWakeEnable_q <= RESET_VALUE_REG[BIT_PD_WAKE_ENABLE];
      sfrMapSelect_q <= RESET_VALUE_REG[BIT_SFR_MAP_SELECT];
    end
    else
    begin
      if (powerModeWr)
      begin
        gpFlagZero_q <= sfrWrData[BIT_GP_FLAG_ZERO];
        gpFlagOne_q <= sfrWrData[BIT_GP_FLAG_ONE];
        baudDouble_q <= sfrWrData[BIT_BAUD_DOUBLE];
      end
      if (wakeCtrlWr)
      begin
        pdWakeEnable_q <= sfrWrData[BIT_PD_WAKE_ENABLE];
      end
      if (systemCtrlWr)
      begin
        sfrMapSelect_q <= sfrWrData[BIT_SFR_MAP_SELECT];
      end
    end
  end

  // ---------------------------------------------------------------
  // reset cause flags
  // ---------------------------------------------------------------
  // hardware set beats both the external clear and a software clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      oscFailResetFlag_q <= 1'b0;
      timerDogResetFlag_q <= 1'b0;
    end
    else
    begin
      if (oscReset)
      begin
        oscFailResetFlag_q <= 1'b1;
      end
      else if (extRst)
      begin
        oscFailResetFlag_q <= 1'b0;
      end
      else if (dogCtrlWr)
      begin
        oscFailResetFlag_q <= sfrWrData[BIT_OSC_FAIL_FLAG];
      end
      // a supervisor reset leaves this flag alone
      if (dogResetEvent)
      begin
        timerDogResetFlag_q <= 1'b1;
      end
      else if (extRst)
      begin
        timerDogResetFlag_q <= 1'b0;
      end
      else if (dogCtrlWr)
      begin
        timerDogResetFlag_q <= sfrWrData[BIT_DOG_FLAG];
      end
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  logic [7:0] rdData_q;
  logic [7:0] rdMux;

  always_comb
  begin
    rdMux = 8'h00;
    if (sfrAddr == ADDR_POWER_MODE)
    begin
      rdMux[BIT_GP_FLAG_ZERO] = gpFlagZero_q;
      rdMux[BIT_GP_FLAG_ONE] = gpFlagOne_q;
      rdMux[BIT_BAUD_DOUBLE] = baudDouble_q;
    end
    else if (sfrAddr == ADDR_WAKE_CTRL && sfrMapSelect_q)
    begin
      rdMux[BIT_PD_WAKE_ENABLE] = pdWakeEnable_q;
    end
    else if (sfrAddr == ADDR_SYSTEM_CTRL)
    begin
      rdMux[BIT_SFR_MAP_SELECT] = sfrMapSelect_q;
    end
    else if (sfrAddr == ADDR_DOG_CTRL)
    begin
      rdMux[BIT_OSC_FAIL_FLAG] = oscFailResetFlag_q;
      rdMux[BIT_DOG_FLAG] = timerDogResetFlag_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdData_q <= 8'h00;
    end
    else if (sfrRdEn)
    begin
      rdData_q <= rdMux;
    end
  end

  // ---------------------------------------------------------------
  // clock, reset and strobe outputs
  // ---------------------------------------------------------------
  logic sysClkSelRc_q;
  logic oscRun_q;
  logic cpuClkEn_q;
  logic periphClkEn_q;
  logic dogHalt_q;
  logic portHold_q;
  logic ale_q;
  logic progStore_q;
  logic pdWakeIrq_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sysClkSelRc_q <= 1'b1;
      chipReset_q <= 1'b1;
      oscRun_q <= 1'b1;
      cpuClkEn_q <= 1'b0;
      periphClkEn_q <= 1'b0;
      dogHalt_q <= 1'b1;
      portHold_q <= 1'b0;
      pdWakeIrq_q <= 1'b0;
    end
    else
    begin
      sysClkSelRc_q <= supState_q != SUP_GOOD;
      chipReset_q <= oscReset || extRst;
      oscRun_q <= mode_q != MODE_PD && !(mode_q == MODE_RUN && pdStart);
      // the CPU freezes with its state held while clocks are off
      cpuClkEn_q <= mode_q == MODE_RUN && !sleepStart && !pdStart;
      periphClkEn_q <= (mode_q == MODE_RUN || mode_q == MODE_IDLE) && !pdStart;
      dogHalt_q <= mode_q != MODE_RUN || oscReset;
      portHold_q <= mode_q == MODE_IDLE || mode_q == MODE_PD;
      pdWakeIrq_q <= mode_q == MODE_WAKE && finalDone;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ale_q <= 1'b0;
      progStore_q <= 1'b0;
    end
    else
    begin
      case (mode_q)
        MODE_IDLE:
        begin
          ale_q <= 1'b1;
          progStore_q <= 1'b1;
        end
        MODE_PD, MODE_WAKE:
        begin
          ale_q <= 1'b0;
          progStore_q <= 1'b0;
        end
        default:
        begin
          ale_q <= aleCore;
          progStore_q <= progStoreStrobeCore;
        end
      endcase
    end
  end

  assign sfrRdData = rdData_q;
  assign sysClkSelRc = sysClkSelRc_q;
  assign rcOscRun = oscRun_q;
  assign xtalOscRun = oscRun_q;
  assign chipReset = chipReset_q;
  assign cpuClkEn = cpuClkEn_q;
  assign periphClkEn = periphClkEn_q;
  assign dogHalt = dogHalt_q;
  assign portHold = portHold_q;
  assign aleOut = ale_q;
  assign progStoreStrobe = progStore_q;
  assign pdWakeIrq = pdWakeIrq_q;
endmodule

/* tb/osc_sup_checker.sv */
// assertion checker for the oscillator supervisor and power modes
`timescale 1ns/10ps
module osc_sup_checker
  import osc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic extResetPin,
  input wire logic irqPending,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic aleOut,
  input wire logic progStoreStrobe,
  input wire logic sysClkSelRc,
  input wire logic rcOscRun,
  input wire logic xtalOscRun,
  input wire logic chipReset,
  input wire logic cpuClkEn,
  input wire logic periphClkEn,
  input wire logic dogHalt,
  input wire logic portHold,
  input wire logic pdWakeIrq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ext_reset_hold: assert property (extResetPin ##1 extResetPin ##1 extResetPin |=> chipReset)
    else $error("external reset did not hold the chip");
  a_release_xtal: assert property ($fell(chipReset) |-> !sysClkSelRc)
    else $error("reset released while rc clock still selected");
  // 16 is below the bench's final phase, but RC is also selected in the failure phase before it, so only RC selection under 16 cycles shows up here
  a_final_phase: assert property ($fell(sysClkSelRc) |-> $past(sysClkSelRc, 16))
    else $error("final reset phase too short");
  a_fail_dog_halt: assert property (sysClkSelRc && chipReset |-> dogHalt)
    else $error("watchdog not halted in supervisor reset");
  a_idle_strobes: assert property (!cpuClkEn && periphClkEn && portHold && !sysClkSelRc |-> aleOut && progStoreStrobe && dogHalt)
    else $error("idle strobes or watchdog halt wrong");
  a_pd_strobes: assert property (!rcOscRun && !$past(rcOscRun) |-> !aleOut && !progStoreStrobe && !cpuClkEn && !xtalOscRun)
    else $error("power-down outputs wrong");
  a_idle_exit: assert property (!cpuClkEn && periphClkEn && irqPending && !sysClkSelRc |-> ##[1:3] cpuClkEn)
    else $error("interrupt did not end idle");
  a_wake_irq: assert property (pdWakeIrq |-> !chipReset ##1 (!pdWakeIrq && cpuClkEn))
    else $error("wake interrupt pulse wrong");
  a_arm_read_zero: assert property (sfrRdEn && sfrAddr == ADDR_POWER_MODE |=> sfrRdData[6:4] == 3'h0 && sfrRdData[1:0] == 2'h0)
    else $error("arm or go bits read back");
  c_idle: cover property (!cpuClkEn && periphClkEn && portHold);
  c_pd: cover property ($fell(rcOscRun));
  c_wake: cover property (pdWakeIrq);
endmodule

bind osc_supervisor_power_modes osc_sup_checker chk (.clk_sys, .rst, .extResetPin, .irqPending, .sfrAddr,
  .sfrRdEn, .sfrRdData, .aleOut, .progStoreStrobe, .sysClkSelRc, .rcOscRun, .xtalOscRun, .chipReset,
  .cpuClkEn, .periphClkEn, .dogHalt, .portHold, .pdWakeIrq);

/* tb/test_osc_supervisor_power_modes.sv */
// self-checking bench for the oscillator supervisor and power modes
`timescale 1ns/10ps
module test_osc_supervisor_power_modes
  import osc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic rcClkPin = 1'b0, xtalClkPin = 1'b0, extWakePin = 1'b1, extResetPin = 1'b0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData;
  logic sfrWrEn = 1'b0, sfrRdEn = 1'b0, irqPending = 1'b0, dogResetEvent = 1'b0;
  logic aleCore = 1'b0, progStoreStrobeCore = 1'b0;
  logic aleOut, progStoreStrobe, sysClkSelRc, rcOscRun, xtalOscRun, chipReset;
  logic cpuClkEn, periphClkEn, dogHalt, portHold, pdWakeIrq;
  logic xtalOn = 1'b0;
  logic [3:0] ph = 4'h0;
  logic [31:0] seed = 32'hB552;
  int err_count = 0;
  int compares = 0;

  always #4 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // oscillator pins
  // ---------------------------------------------------------------
  // pins follow the run outputs, so a stopped oscillator really stops
  always @(posedge clk_sys)
  begin
    ph <= ph + 4'h1;
    rcClkPin <= rcOscRun & ph[3];
    xtalClkPin <= xtalOn & xtalOscRun & ph[1];
    aleCore <= ph[0];
    progStoreStrobeCore <= ph[2];
  end

  osc_supervisor_power_modes #(.FINAL_CYCLES(20)) dut (.clk_sys, .rst, .rcClkPin, .xtalClkPin, .extWakePin,
    .extResetPin, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData, .irqPending, .dogResetEvent, .aleCore,
    .progStoreStrobeCore, .aleOut, .progStoreStrobe, .sysClkSelRc, .rcOscRun, .xtalOscRun, .chipReset,
    .cpuClkEn, .periphClkEn, .dogHalt, .portHold, .pdWakeIrq);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function logic sig(input int s);
    case (s)
      0: return chipReset;
      1: return pdWakeIrq;
      default: return cpuClkEn;
    endcase
  endfunction

  task stop_test();
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task waitFor(input int s, input logic v, input int lim);
    int n;
    n = 0;
    // step off the launching edge so the outputs have settled
    #1;
    while (sig(s) !== v && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (sig(s) !== v)
    begin
      err_count++;
      $display("[FAIL] wait %0d expected %b seen timeout", s, v);
      stop_test();
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge clk_sys);
    sfrWrEn <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clk_sys);
    sfrRdEn <= 1'b0;
    #1;
    v = sfrRdData;
  endtask

  task settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [7:0] v;
    logic [7:0] d;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (100) @(posedge clk_sys);
    #1;
    chk("chipReset", 8'h01, chipReset);
    chk("sysClkSelRc", 8'h01, sysClkSelRc);
    rd(ADDR_DOG_CTRL, v);
    chk("flags", 8'h08, v);
    @(posedge clk_sys);
    xtalOn <= 1'b1;
    waitFor(0, 1'b0, 1000);
    chk("sysClkSelRc", 8'h00, sysClkSelRc);
    // crystal loss keeps the dog flag and sets the failure flag
    @(posedge clk_sys);
    dogResetEvent <= 1'b1;
    @(posedge clk_sys);
    dogResetEvent <= 1'b0;
    xtalOn <= 1'b0;
    waitFor(0, 1'b1, 400);
    chk("dogHalt", 8'h01, dogHalt);
    chk("sysClkSelRc", 8'h01, sysClkSelRc);
    rd(ADDR_DOG_CTRL, v);
    chk("flags", 8'h0C, v);
    @(posedge clk_sys);
    xtalOn <= 1'b1;
    extResetPin <= 1'b1;
    repeat (400) @(posedge clk_sys);
    #1;
    chk("chipReset", 8'h01, chipReset);
    @(posedge clk_sys);
    extResetPin <= 1'b0;
    waitFor(0, 1'b0, 20);
    rd(ADDR_DOG_CTRL, v);
    chk("flags", 8'h00, v);
    // arm and go written together never start a mode
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      d = (seed[7:0] & 8'h8C) | 8'h63;
      wr(ADDR_POWER_MODE, d);
      rd(ADDR_POWER_MODE, v);
      chk("power_mode", d & 8'h8C, v);
      chk("cpuClkEn", 8'h01, cpuClkEn);
    end
    wr(ADDR_WAKE_CTRL, 8'h80);
    rd(ADDR_WAKE_CTRL, v);
    chk("wake_ctrl", 8'h00, v);
    wr(ADDR_SYSTEM_CTRL, 8'h10);
    wr(ADDR_WAKE_CTRL, 8'h80);
    rd(ADDR_WAKE_CTRL, v);
    chk("wake_ctrl", 8'h80, v);
    rd(8'h90, v);
    chk("unmapped", 8'h00, v);
    wr(ADDR_DOG_CTRL, 8'h0C);
    rd(ADDR_DOG_CTRL, v);
    chk("flags", 8'h0C, v);
    wr(ADDR_DOG_CTRL, 8'h00);
    rd(ADDR_DOG_CTRL, v);
    chk("flags", 8'h00, v);
    // an intervening power mode write disarms idle
    wr(ADDR_POWER_MODE, 8'h01);
    wr(ADDR_POWER_MODE, 8'h04);
    wr(ADDR_POWER_MODE, 8'h20);
    settle();
    chk("cpuClkEn", 8'h01, cpuClkEn);
    wr(ADDR_POWER_MODE, 8'h01);
    wr(ADDR_POWER_MODE, 8'h20);
    settle();
    chk("cpuClkEn", 8'h00, cpuClkEn);
    chk("periphClkEn", 8'h01, periphClkEn);
    chk("strobes", 8'h03, {aleOut, progStoreStrobe});
    chk("portHold", 8'h01, portHold);
    @(posedge clk_sys);
    irqPending <= 1'b1;
    waitFor(2, 1'b1, 10);
    @(posedge clk_sys);
    irqPending <= 1'b0;
    // both go bits at once: power-down wins
    wr(ADDR_POWER_MODE, 8'h03);
    wr(ADDR_POWER_MODE, 8'h60);
    settle();
    chk("oscRun", 8'h00, {rcOscRun, xtalOscRun});
    chk("strobes", 8'h00, {aleOut, progStoreStrobe});
    chk("periphClkEn", 8'h00, periphClkEn);
    @(posedge clk_sys);
    extWakePin <= 1'b0;
    waitFor(1, 1'b1, 2000);
    chk("chipReset", 8'h00, chipReset);
    @(posedge clk_sys);
    extWakePin <= 1'b1;
    stop_test();
  end
endmodule
